// *** abr_defs.vh ***
// constants for the asynchronous block receive formatter
// Notes on behaviour
// - status token is first stored quadlet
// - token carries stored length in quadlets
// - self-id flag set for self-id packets
// - phy flag set for phy packets
// - token holds five-bit acknowledge result
// - token reports number of pad bytes
// - speed code 00/01/10, 11 unused
// - destination id: bus ten, node six bits
// - transaction label stored unchanged
// - retry code stored as received
// - transaction code stored as received
// - source id in sixteen-bit field
// - 48-bit offset over two quadlets
// - lock response code in offset top bits
// - no payload for block read req, write resp
// - data length meaning per transaction type
// - data length stored as given, even with no payload
// - extended code shares quadlet with length
// - first payload byte in byte zero
// - final quadlet zero padded
// - ack 0_0001 complete, 0_0010 pending
`ifndef ABR_DEFS_VH
`define ABR_DEFS_VH
`define ABR_REG_CTRL      4'h0
`define ABR_REG_STATUS    4'h4
`define ABR_REG_RDDATA    4'h8
`define ABR_REG_COUNT     4'hC
`define ABR_CTRL_EN_BIT   0
`define ABR_CTRL_FLUSH_BIT 1
`define ABR_CTRL_RESET    2'h1
`define ABR_BUF_DEPTH     64
`define ABR_BUF_AW        6
`define ABR_TOK_SIZE_LSB  16
`define ABR_TOK_S_BIT     15
`define ABR_TOK_P_BIT     14
`define ABR_TOK_ACK_LSB   8
`define ABR_TOK_PAD_LSB   6
`define ABR_TOK_SPD_LSB   4
`define ABR_ACK_COMPLETE  5'h01
`define ABR_ACK_PENDING   5'h02
`define ABR_SPD_S100      2'h0
`define ABR_SPD_S200      2'h1
`define ABR_SPD_S400      2'h2
`define ABR_TC_WR_RESP    4'h2
`define ABR_TC_BLK_RDREQ  4'h5
`define ABR_TC_LOCK_RESP  4'hB
`define ABR_HDR_QUADS     4
`endif

// *** abr_formatter.v ***
// receive formatter: bus-side packet in, token plus quadlets into buffer, axi-lite host side
`timescale 1ns/1ns
`include "abr_defs.vh"
module abr_formatter (
	input  wire        ref_clk,
	input  wire        reset_n,
	input  wire        clkEn,
	// link side: packet header fields given at start, then payload bytes
	input  wire        pktStart,
	input  wire [15:0] pktDestId,
	input  wire [5:0]  pktLabel,
	input  wire [1:0]  pktRetry,
	input  wire [3:0]  pktTcode,
	input  wire [3:0]  pktPriority,
	input  wire [15:0] pktSrcId,
	input  wire [15:0] pktOffsetHigh,
	input  wire [31:0] pktOffsetLow,
	input  wire [15:0] pktDataLength,
	input  wire [15:0] pktExtTcode,
	input  wire        pktSelfId,
	input  wire        pktPhy,
	input  wire [1:0]  pktSpeed,
	input  wire        byteValid,
	input  wire [7:0]  byteData,
	input  wire        pktEnd,
	input  wire [4:0]  ackResult,
	output wire        linkReady,
	output reg         pktDropped_ff,
	// axi4-lite slave
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// overview
// the link side hands over one packet at a time: the header fields as levels
// with a start pulse, then the payload one byte per cycle, then an end pulse
// that carries the acknowledge result.
// the buffer is a plain ring of quadlets. a packet owns a run of words that
// starts with one reserved slot for its status token, then four header
// quadlets, then the packed payload. the token is written last, so that it
// already carries the final quadlet count and pad count, and only then the
// commit pointer moves past the packet.
// the host pops committed quadlets one at a time through the data register.
// words of a packet still being written are counted as pending, not as used,
// so the host never sees a half-stored packet.
// limitations a user must know:
// - a start pulse outside idle is ignored; the link must wait for the
//   previous packet to commit.
// - a packet is refused whole at its start unless the header, the token and
//   one more word fit; once past that point the link is only throttled, never cut, so a
//   payload larger than the free room stalls until the host reads.
// - the data length word is stored as the link gives it; it is not checked
//   against the bytes that really arrive.
// - a flush drops every committed word; a packet in flight survives it unless the flush lands in its commit cycle.
// - while the clock enable is low every ready output is held low as well,
//   so no byte, address, write data or read address is taken during a freeze and nothing is lost.
// register map, one aligned word each:
// - 0x0 control: bit 0 enable, bit 1 flush (self-clearing)
// - 0x4 status: committed words and framing state, read only
// - 0x8 data: pops one committed quadlet, zero when empty
// - 0xC packet count: packets committed since reset
// any other offset answers with a slave error.

////////////////////////////////////////////////////////////////////////////////
// state codes
localparam ST_IDLE = 3'h0;
localparam ST_HDR  = 3'h1;
localparam ST_DATA = 3'h2;
localparam ST_ACK  = 3'h3;
localparam ST_TOK  = 3'h4;

reg  [31:0]               bufMem [0:`ABR_BUF_DEPTH-1];
reg  [2:0]                state_ff;
reg  [`ABR_BUF_AW-1:0]    wrPtr_ff;
reg  [`ABR_BUF_AW-1:0]    commitPtr_ff;
reg  [`ABR_BUF_AW-1:0]    rdPtr_ff;
reg  [`ABR_BUF_AW-1:0]    pktBase_ff;
reg  [`ABR_BUF_AW:0]      usedWords_ff;
reg  [`ABR_BUF_AW:0]      pendWords_ff;
reg  [2:0]                hdrIdx_ff;
reg  [31:0]               hdrQ_ff [0:3];
reg  [31:0]               assemble_ff;
reg  [1:0]                bytePos_ff;
reg  [15:0]               byteCnt_ff;
reg  [7:0]                quadCnt_ff;
reg                       selfId_ff;
reg                       phy_ff;
reg  [1:0]                speed_ff;
reg  [4:0]                ack_ff;
reg                       noPayload_ff;
reg  [1:0]                ctrl_ff;
reg  [31:0]               pktCount_ff;
reg                       awHeld_ff;
reg                       wHeld_ff;
reg  [3:0]                awAddr_ff;
reg  [31:0]               wData_ff;

reg  [`ABR_BUF_AW:0]      nxt_usedWords;

wire enable    = ctrl_ff[`ABR_CTRL_EN_BIT];
// free room reckoned wide, then cut: depth itself needs the extra bit
wire [31:0] freeFull = `ABR_BUF_DEPTH - usedWords_ff - pendWords_ff;
wire [`ABR_BUF_AW:0] freeWords = freeFull[`ABR_BUF_AW:0];
wire bufEmpty  = (usedWords_ff == {(`ABR_BUF_AW+1){1'b0}});
// pad is what tops the byte count up to a whole quadlet
wire [1:0] padBytes = 2'h0 - byteCnt_ff[1:0];

// status token fields, most significant first; reserved lanes tied low
wire [7:0]  tokQuads  = quadCnt_ff;
wire [4:0]  tokAck    = ack_ff;
wire [31:0] tokWord   = {8'h00,
	tokQuads,
	selfId_ff,
	phy_ff,
	1'b0,
	tokAck,
	padBytes,
	speed_ff,
	4'h0};

// link may only stream bytes while data phase has room for one quadlet;
// gated by the clock enable so that a frozen block takes no byte
assign linkReady = (state_ff == ST_DATA) && (freeWords > 0) && clkEn;

////////////////////////////////////////////////////////////////////////////////
// packet framing: reserve token slot, write header, pack payload, then token
always @(posedge ref_clk or negedge reset_n) begin
	if (!reset_n) begin
		state_ff      <= ST_IDLE;
		wrPtr_ff      <= {`ABR_BUF_AW{1'b0}};
		commitPtr_ff  <= {`ABR_BUF_AW{1'b0}};
		pktBase_ff    <= {`ABR_BUF_AW{1'b0}};
		pendWords_ff  <= {(`ABR_BUF_AW+1){1'b0}};
		hdrIdx_ff     <= 3'h0;
		assemble_ff   <= 32'h0000_0000;
		bytePos_ff    <= 2'h0;
		byteCnt_ff    <= 16'h0000;
		quadCnt_ff    <= 8'h00;
		selfId_ff     <= 1'b0;
		phy_ff        <= 1'b0;
		speed_ff      <= 2'h0;
		ack_ff        <= 5'h00;
		noPayload_ff  <= 1'b0;
		pktDropped_ff <= 1'b0;
		pktCount_ff   <= 32'h0000_0000;
		hdrQ_ff[0]    <= 32'h0000_0000;
		hdrQ_ff[1]    <= 32'h0000_0000;
		hdrQ_ff[2]    <= 32'h0000_0000;
		hdrQ_ff[3]    <= 32'h0000_0000;
	end else if (clkEn) begin
		pktDropped_ff <= 1'b0;
		case (state_ff)
		ST_IDLE: begin
			if (pktStart && enable) begin
				// a full packet header plus token plus one more word must fit, else drop it whole
				if (freeWords < `ABR_HDR_QUADS + 2) begin
					pktDropped_ff <= 1'b1;
				end else begin
					pktBase_ff   <= wrPtr_ff;
					wrPtr_ff     <= wrPtr_ff + 1'b1;
					pendWords_ff <= {{`ABR_BUF_AW{1'b0}}, 1'b1};
					hdrQ_ff[0]   <= {pktDestId, pktLabel, pktRetry,
						pktTcode, pktPriority};
					// lock response code rides in the offset top nibble unchanged
					hdrQ_ff[1]   <= {pktSrcId, pktOffsetHigh};
					hdrQ_ff[2]   <= pktOffsetLow;
					hdrQ_ff[3]   <= {pktDataLength, pktExtTcode};
					noPayload_ff <= (pktTcode == `ABR_TC_BLK_RDREQ) ||
						(pktTcode == `ABR_TC_WR_RESP);
					selfId_ff    <= pktSelfId;
					phy_ff       <= pktPhy;
					speed_ff     <= pktSpeed;
					hdrIdx_ff    <= 3'h0;
					quadCnt_ff   <= 8'h01;
					byteCnt_ff   <= 16'h0000;
					bytePos_ff   <= 2'h0;
					assemble_ff  <= 32'h0000_0000;
					state_ff     <= ST_HDR;
				end
			end
		end
		ST_HDR: begin
			bufMem[wrPtr_ff] <= hdrQ_ff[hdrIdx_ff[1:0]];
			wrPtr_ff     <= wrPtr_ff + 1'b1;
			pendWords_ff <= pendWords_ff + 1'b1;
			quadCnt_ff   <= quadCnt_ff + 1'b1;
			hdrIdx_ff    <= hdrIdx_ff + 1'b1;
			if (hdrIdx_ff == 3'h3)
				state_ff <= ST_DATA;
		end
		ST_DATA: begin
			if (byteValid && linkReady && !noPayload_ff) begin
				byteCnt_ff <= byteCnt_ff + 1'b1;
				bytePos_ff <= bytePos_ff + 1'b1;
				// byte 0 sits in the top lane, big-endian like the header
				if (bytePos_ff == 2'h3) begin
					bufMem[wrPtr_ff] <= {assemble_ff[31:8], byteData};
					wrPtr_ff     <= wrPtr_ff + 1'b1;
					pendWords_ff <= pendWords_ff + 1'b1;
					quadCnt_ff   <= quadCnt_ff + 1'b1;
					assemble_ff  <= 32'h0000_0000;
				end else begin
					assemble_ff[8*(3-bytePos_ff) +: 8] <= byteData;
				end
			end else if (pktEnd) begin
				// partial quadlet left: already zero in unused lanes
				if (bytePos_ff != 2'h0) begin
					bufMem[wrPtr_ff] <= assemble_ff;
					wrPtr_ff     <= wrPtr_ff + 1'b1;
					pendWords_ff <= pendWords_ff + 1'b1;
					quadCnt_ff   <= quadCnt_ff + 1'b1;
				end
				ack_ff   <= ackResult;
				state_ff <= ST_TOK;
			end
		end
		ST_TOK: begin
			// token written last into the reserved slot so it sees final counts
			bufMem[pktBase_ff] <= tokWord;
			commitPtr_ff <= wrPtr_ff;
			pendWords_ff <= {(`ABR_BUF_AW+1){1'b0}};
			pktCount_ff  <= pktCount_ff + 1'b1;
			state_ff     <= ST_IDLE;
		end
		default: state_ff <= ST_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write path: address and data taken in either order
wire wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;
// readies drop during a freeze: a transfer taken then would be lost
assign s_axi_awready = !awHeld_ff && clkEn;
assign s_axi_wready  = !wHeld_ff && clkEn;

always @(posedge ref_clk or negedge reset_n) begin
	if (!reset_n) begin
		awHeld_ff    <= 1'b0;
		wHeld_ff     <= 1'b0;
		awAddr_ff    <= 4'h0;
		wData_ff     <= 32'h0000_0000;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp  <= 2'h0;
		ctrl_ff      <= `ABR_CTRL_RESET;
	end else if (clkEn) begin
		if (s_axi_awvalid && !awHeld_ff) begin
			awHeld_ff <= 1'b1;
			awAddr_ff <= s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_ff) begin
			wHeld_ff <= 1'b1;
			wData_ff <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
		end
		if (wrFire) begin
			awHeld_ff    <= 1'b0;
			wHeld_ff     <= 1'b0;
			s_axi_bvalid <= 1'b1;
			if (awAddr_ff == `ABR_REG_CTRL) begin
				ctrl_ff     <= wData_ff[1:0] & 2'h1;  // flush self-clears
				s_axi_bresp <= 2'h0;
			end else begin
				s_axi_bresp <= 2'h2;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read path: reading the data register pops one committed quadlet
wire rdFire = s_axi_arvalid && !s_axi_rvalid;
assign s_axi_arready = !s_axi_rvalid && clkEn;
wire popWord = rdFire && (s_axi_araddr == `ABR_REG_RDDATA) && !bufEmpty;
wire flushReq = wrFire && (awAddr_ff == `ABR_REG_CTRL) && wData_ff[`ABR_CTRL_FLUSH_BIT];

always @(posedge ref_clk or negedge reset_n) begin
	if (!reset_n) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata  <= 32'h0000_0000;
		s_axi_rresp  <= 2'h0;
		rdPtr_ff     <= {`ABR_BUF_AW{1'b0}};
	end else if (clkEn) begin
		if (rdFire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case (s_axi_araddr)
			`ABR_REG_CTRL:   s_axi_rdata <= {30'h0, ctrl_ff};
			`ABR_REG_STATUS: s_axi_rdata <= {16'h0, 5'h0, state_ff,
				1'b0, usedWords_ff};
			`ABR_REG_RDDATA: s_axi_rdata <= bufEmpty ? 32'h0000_0000 : bufMem[rdPtr_ff];
			`ABR_REG_COUNT:  s_axi_rdata <= pktCount_ff;
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
		// a flush in the commit cycle must skip the packet dropped with it,
		// or the read pointer would lag the next packet's token slot
		if (flushReq)
			rdPtr_ff <= (state_ff == ST_TOK) ? wrPtr_ff : commitPtr_ff;
		else if (popWord)
			rdPtr_ff <= rdPtr_ff + 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// next committed count: flush wins, a commit folds in a same-cycle pop
always @* begin
	nxt_usedWords = usedWords_ff;
	if (flushReq) begin
		nxt_usedWords = {(`ABR_BUF_AW+1){1'b0}};
	end else if (state_ff == ST_TOK) begin
		nxt_usedWords = usedWords_ff + pendWords_ff -
			{{`ABR_BUF_AW{1'b0}}, popWord};
	end else if (popWord) begin
		nxt_usedWords = usedWords_ff - {{`ABR_BUF_AW{1'b0}}, 1'b1};
	end
end

// committed word count: grows on token commit, shrinks on host pop
always @(posedge ref_clk or negedge reset_n) begin
	if (!reset_n) begin
		usedWords_ff <= {(`ABR_BUF_AW+1){1'b0}};
	end else if (clkEn) begin
		usedWords_ff <= nxt_usedWords;
	end
end

endmodule

// *** abr_formatter_props.sv ***
// concurrent checks on the formatter's link and host ports
`timescale 1ns/1ns
module abr_formatter_props (
	input wire        ref_clk,
	input wire        reset_n,
	input wire        pktStart,
	input wire        pktEnd,
	input wire        byteValid,
	input wire        linkReady,
	input wire        pktDropped_ff,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////
	// header cycles come before any payload byte is taken
	property p_hdr; pktStart && !linkReady |=> !linkReady [*3]; endproperty
	a_hdr: assert property (p_hdr) else $error("payload open during header");
	property p_end; linkReady && pktEnd && !byteValid |=> !linkReady [*2]; endproperty
	a_end: assert property (p_end) else $error("link still open after end");
	property p_drop; pktDropped_ff |-> !linkReady ##1 !linkReady; endproperty
	a_drop: assert property (p_drop) else $error("dropped packet opened link");
	// host side answers stand until taken
	property p_bst; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bst: assert property (p_bst) else $error("write answer withdrawn");
	property p_rst;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rst: assert property (p_rst) else $error("read answer changed");
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rblk: assert property (p_rblk) else $error("read taken while busy");
	property p_bans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
	endproperty
	a_bans: assert property (p_bans) else $error("write answer late");
	property p_err; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("error read not zero");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_pk: cover property (linkReady && pktEnd);
endmodule
bind abr_formatter abr_formatter_props i_abr_formatter_props (.*);

// *** abr_host_model.sv ***
// host processor model: axi4-lite master reading the receive buffer
`timescale 1ns/1ns
module abr_host_model (
	input  wire        ref_clk,
	output reg  [3:0]  s_axi_awaddr,
	output reg         s_axi_awvalid,
	input  wire        s_axi_awready,
	output reg  [31:0] s_axi_wdata,
	output reg  [3:0]  s_axi_wstrb,
	output reg         s_axi_wvalid,
	input  wire        s_axi_wready,
	output reg         s_axi_bready,
	input  wire [1:0]  s_axi_bresp,
	input  wire        s_axi_bvalid,
	output reg  [3:0]  s_axi_araddr,
	output reg         s_axi_arvalid,
	input  wire        s_axi_arready,
	input  wire [31:0] s_axi_rdata,
	input  wire [1:0]  s_axi_rresp,
	input  wire        s_axi_rvalid,
	output reg         s_axi_rready
);
	int stall = 0; // a slow host lets each answer wait this many cycles
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		repeat (stall) @(posedge ref_clk);
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat (stall) @(posedge ref_clk);
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// *** abr_formatter_tb_top.sv ***
// self-checking bench for the block receive formatter
`timescale 1ns/1ns
module abr_formatter_tb_top;
	typedef struct {logic [3:0] tc; logic [15:0] len; logic s, p;
		logic [1:0] spd; logic [4:0] ack;} abr_row_t;
	logic        ref_clk, reset_n, clkEn, pktStart, pktSelfId, pktPhy, byteValid, pktEnd;
	logic [15:0] pktDestId, pktSrcId, pktOffsetHigh, pktDataLength, pktExtTcode;
	logic [31:0] pktOffsetLow, s_axi_wdata, s_axi_rdata;
	logic [5:0]  pktLabel;
	logic [4:0]  ackResult;
	logic [3:0]  pktTcode, pktPriority, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [1:0]  pktRetry, pktSpeed, s_axi_bresp, s_axi_rresp, wrResp;
	logic [7:0]  byteData;
	logic        linkReady, pktDropped_ff, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, dropSeen;
	int          n_fail, comparisons, cyc, i;
	abr_row_t    rows [5];
	abr_formatter i_abr_formatter (.*);
	abr_host_model i_abr_host_model (.*);
	////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// hang guard and refusal monitor
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (pktDropped_ff === 1'b1)
			dropSeen <= 1'b1;
		if (cyc == 30000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] x);
		comparisons++;
		if (got !== x) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, x);
		end
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] x, input logic [1:0] xr);
		logic [31:0] d;
		logic [1:0]  r;
		i_abr_host_model.rd(a, d, r);
		cmp(d, x);
		cmp({30'h0, r}, {30'h0, xr});
	endtask
	function automatic logic [7:0] pay(input int j, input int nb);
		return (j < nb) ? 8'hA0 + 8'(j) : 8'h00;
	endfunction
	////////////////////////////////////////////////////////////
	// one packet in over the link; expected quadlets built first, then read back
	task automatic pkt(input abr_row_t r, input int n, input bit back);
		int          nb, nq, k;
		logic [1:0]  pad;
		logic [31:0] e [$];
		nb = (r.tc == 4'h5 || r.tc == 4'h2) ? 0 : r.len;
		pad = 2'(4 - nb % 4);
		nq = 5 + (nb + 3) / 4;
		e.push_back({8'h0, 8'(nq), r.s, r.p, 1'b0, r.ack, pad, r.spd, 4'h0});
		e.push_back({10'h155, 6'(n), 6'h20 + 6'(n), 2'(n), r.tc, 4'h0});
		e.push_back({16'hFFC0 + 16'(n), 4'(n), 12'hABC});
		e.push_back(32'h89AB_CDEC);
		e.push_back({r.len, 16'(n)});
		for (k = 0; k < nb; k += 4)
			e.push_back({pay(k, nb), pay(k + 1, nb), pay(k + 2, nb), pay(k + 3, nb)});
		@(posedge ref_clk);
		pktStart <= 1'b1;
		{pktDestId, pktLabel, pktRetry, pktTcode} <= {e[1][31:8], r.tc};
		{pktSrcId, pktOffsetHigh, pktOffsetLow} <= {e[2], e[3]};
		{pktDataLength, pktExtTcode} <= e[4];
		{pktSelfId, pktPhy, pktSpeed} <= {r.s, r.p, r.spd};
		@(posedge ref_clk);
		pktStart <= 1'b0;
		for (k = 0; k < nb; k++) begin
			byteValid <= 1'b1;
			byteData <= 8'hA0 + 8'(k);
			do @(posedge ref_clk); while (linkReady !== 1'b1);
		end
		byteValid <= 1'b0;
		pktEnd <= 1'b1;
		ackResult <= r.ack;
		do @(posedge ref_clk); while (linkReady !== 1'b1);
		pktEnd <= 1'b0;
		repeat (3) @(posedge ref_clk);
		if (back)
			foreach (e[j]) rdc(4'h8, e[j], 2'h0);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		{reset_n, pktStart, pktSelfId, pktPhy, byteValid, pktEnd, dropSeen} = '0;
		{pktDestId, pktSrcId, pktOffsetHigh, pktDataLength, pktExtTcode, pktOffsetLow} = '0;
		{pktLabel, ackResult, pktTcode, pktRetry, pktSpeed, byteData} = '0;
		pktPriority = 4'h0;
		clkEn = 1'b1;
		rows = '{'{4'h1, 16'h5, 1'b0, 1'b0, 2'h0, 5'h01}, '{4'h7, 16'h8, 1'b1, 1'b0, 2'h1, 5'h02},
			'{4'h5, 16'h10, 1'b0, 1'b1, 2'h2, 5'h0D}, '{4'hB, 16'h6, 1'b0, 1'b0, 2'h0, 5'h10},
			'{4'h2, 16'h0, 1'b0, 1'b0, 2'h1, 5'h01}};
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		rdc(4'h0, 32'h1, 2'h0);
		rdc(4'h8, 32'h0, 2'h0);
		rdc(4'h2, 32'h0, 2'h2);
		for (i = 0; i < 5; i++) begin
			i_abr_host_model.stall = i % 3;
			pkt(rows[i], i, 1'b1);
		end
		rdc(4'hC, 32'h5, 2'h0);
		rdc(4'h4, 32'h0, 2'h0);
		// fill to one free word; the next start must be refused, then flush recovers
		for (i = 0; i < 9; i++)
			pkt(rows[1], i, 1'b0);
		cmp({31'h0, dropSeen}, 32'h0);
		@(posedge ref_clk);
		pktStart <= 1'b1;
		@(posedge ref_clk);
		pktStart <= 1'b0;
		repeat (4) @(posedge ref_clk);
		cmp({31'h0, dropSeen}, 32'h1);
		i_abr_host_model.wr(4'h4, 32'h0, wrResp);
		cmp({30'h0, wrResp}, 32'h2);
		i_abr_host_model.wr(4'h0, 32'h3, wrResp);
		cmp({30'h0, wrResp}, 32'h0);
		rdc(4'h8, 32'h0, 2'h0);
		// frozen clock enable: a start pulse meanwhile must leave no trace
		clkEn <= 1'b0;
		pktStart <= 1'b1;
		repeat (2) @(posedge ref_clk);
		pktStart <= 1'b0;
		clkEn <= 1'b1;
		rdc(4'h4, 32'h0, 2'h0);
		pkt(rows[0], 7, 1'b1);
		rdc(4'hC, 32'hF, 2'h0);
		conclude();
	end
endmodule
